// ==== src/camera_control_status_regs.sv ====
`timescale 1ns/1ps
`include "camera_regs_defs.svh"
module camera_control_status_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic continuous_on,
  input wire logic single_shot_req,
  input wire logic multi_shot_req,
  input wire logic [11:0] replay_count,
  input wire logic frame_arrive,
  input wire logic live_sent,
  input wire logic fmt_change,
  input wire logic [11:0] store_capacity_in,
  input wire logic tx_ready,
  input wire logic global_reset_shutter,
  input wire logic [5:0] flash_rd_idx,
  output logic frame_send,
  output camera_regs_pkg::send_src_t frame_send_src,
  output logic [11:0] frame_send_slot,
  output logic frame_send_undef,
  output logic store_write,
  output logic [11:0] store_slot,
  output logic flash_commit,
  output logic [31:0] flash_rd_word,
  output logic strobe_ref_trigger,
  output logic [1:0] strobe_span,
  output logic aux_supply_on,
  output logic window_on,
  output logic [31:0] window_origin,
  output logic [31:0] window_extent
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [15:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, rd_fire, rd_hit, wr_hit;
  logic [31:0] rd_mux;

  // handshakes masked while frozen, else the master sees a transfer that never lands
  assign s_axi_awready = ce && !aw_held_r && !bvalid_r;
  assign s_axi_wready = ce && !w_held_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid = ce && bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = ce && rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;

  function automatic logic hit(input logic [15:0] a);
    hit = (a == `OFS_REPLAY) || (a == `OFS_STROBE) || (a == `OFS_FLASH_CTRL) ||
      (a == `OFS_FLASH_DATA) || (a == `OFS_AUX) || (a == `OFS_WIN_CTRL) ||
      (a == `OFS_WIN_BASE) || (a == `OFS_WIN_POS_STEP) || (a == `OFS_WIN_SIZE_STEP) ||
      (a == `OFS_WIN_ORIGIN) || (a == `OFS_WIN_EXTENT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
      input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) merge[i*8 +: 8] = n[i*8 +: 8];
    end
  endfunction

  assign wr_hit = hit(aw_addr_r);
  assign rd_hit = hit(s_axi_araddr);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 16'h0000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_hit ? rd_mux : 32'h00000000;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic store_on_r, sel_r, strobe_ref_r, aux_on_r, win_on_r, dirty_r;
  logic [1:0] span_r;
  logic [31:0] origin_r, extent_r, window_word_r;
  logic [11:0] cap_r, fill_r;
  logic [31:0] wd_replay, wd_strobe, wd_flash, wd_aux, wd_win, wd_org, wd_ext;
  logic wr_replay, wr_strobe, wr_flash, wr_data, wr_aux, wr_win, wr_org, wr_ext;
  logic other_access, commit, reinit;

  assign wr_replay = wr_fire && aw_addr_r == `OFS_REPLAY;
  assign wr_strobe = wr_fire && aw_addr_r == `OFS_STROBE;
  assign wr_flash = wr_fire && aw_addr_r == `OFS_FLASH_CTRL;
  assign wr_data = wr_fire && aw_addr_r == `OFS_FLASH_DATA;
  assign wr_aux = wr_fire && aw_addr_r == `OFS_AUX;
  assign wr_win = wr_fire && aw_addr_r == `OFS_WIN_CTRL;
  assign wr_org = wr_fire && aw_addr_r == `OFS_WIN_ORIGIN;
  assign wr_ext = wr_fire && aw_addr_r == `OFS_WIN_EXTENT;
  // unused bits of the old value are zero, so merged reserved bits are dropped
  assign wd_replay = merge({store_on_r, sel_r, 30'h0}, w_data_r, w_strb_r);
  assign wd_strobe = merge({strobe_ref_r, 13'h0, span_r, 16'h0}, w_data_r, w_strb_r);
  assign wd_flash = merge(32'h00000000, w_data_r, w_strb_r);
  assign wd_aux = merge({31'h0, aux_on_r}, w_data_r, w_strb_r);
  assign wd_win = merge({6'h0, win_on_r, 25'h0}, w_data_r, w_strb_r);
  assign wd_org = merge(origin_r, w_data_r, w_strb_r);
  assign wd_ext = merge(extent_r, w_data_r, w_strb_r);

  assign other_access = (wr_fire && wr_hit && !wr_flash && !wr_data) ||
    (rd_fire && rd_hit && s_axi_araddr != `OFS_FLASH_CTRL &&
     s_axi_araddr != `OFS_FLASH_DATA);
  assign commit = dirty_r && ((wr_flash && wd_flash[`FLASH_CLEAN_BIT]) || other_access);
  assign reinit = (wr_replay && wd_replay[`RPL_ON_BIT]) || fmt_change;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      store_on_r <= 1'b0;
      sel_r <= 1'b0;
    end else if (ce && wr_replay) begin
      store_on_r <= wd_replay[`RPL_ON_BIT];
      sel_r <= wd_replay[`RPL_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      strobe_ref_r <= 1'b0;
      span_r <= 2'h0;
    end else if (ce && wr_strobe) begin
      strobe_ref_r <= wd_strobe[`STB_REF_BIT];
      // any-pixel needs global reset; code 3 is never stored
      if (wd_strobe[`STB_SPAN_MSB:`STB_SPAN_LSB] != 2'h3 &&
          (wd_strobe[`STB_SPAN_MSB:`STB_SPAN_LSB] != 2'h1 || global_reset_shutter)) begin
        span_r <= wd_strobe[`STB_SPAN_MSB:`STB_SPAN_LSB];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) aux_on_r <= 1'b0;
    else if (ce && wr_aux) aux_on_r <= wd_aux[`AUX_ON_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      win_on_r <= 1'b0;
      origin_r <= 32'h00000000;
      extent_r <= 32'h00000000;
    end else if (ce) begin
      if (wr_win) win_on_r <= wd_win[`WIN_ON_BIT];
      if (wr_org && win_on_r) origin_r <= wd_org;
      if (wr_ext && win_on_r) extent_r <= wd_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash page buffer

  logic [31:0] page_mem [`PAGE_WORDS];
  logic [5:0] page_ptr_r;
  logic commit_r;
  logic [31:0] flash_rd_r;

  // buffer restarts erased after each commit not met by a data write in the same cycle, so untouched words program as ones
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < `PAGE_WORDS; i++) page_mem[i] <= 32'hFFFFFFFF;
      page_ptr_r <= 6'h00;
      dirty_r <= 1'b0;
      window_word_r <= 32'h00000000;
      commit_r <= 1'b0;
    end else if (ce) begin
      commit_r <= commit;
      if (wr_data) begin
        page_mem[page_ptr_r] <= w_data_r;
        page_ptr_r <= page_ptr_r + 6'h01;
        window_word_r <= w_data_r;
        dirty_r <= 1'b1;
      end else if (commit) begin
        for (int i = 0; i < `PAGE_WORDS; i++) page_mem[i] <= 32'hFFFFFFFF;
        page_ptr_r <= 6'h00;
        dirty_r <= 1'b0;
      end
    end
  end

  // page is erased as the commit pulse rises; programmer sees only one pre-erasure word, registered from the index of the cycle before
  always_ff @(posedge core_clk) begin
    if (!resetn) flash_rd_r <= 32'hFFFFFFFF;
    else if (ce) flash_rd_r <= page_mem[flash_rd_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr)
      `OFS_REPLAY: rd_mux = {store_on_r, sel_r, 6'h00, cap_r, fill_r};
      `OFS_STROBE: rd_mux = {strobe_ref_r, 12'h000, global_reset_shutter, span_r, 16'h0000};
      `OFS_FLASH_CTRL: rd_mux = {1'b1, 5'h00, !dirty_r, 1'b0, `FLASH_PAGE_EXP,
        `FLASH_COUNT_EXP};
      `OFS_FLASH_DATA: rd_mux = window_word_r;
      `OFS_AUX: rd_mux = {1'b1, 30'h00000000, aux_on_r};
      `OFS_WIN_CTRL: rd_mux = {1'b1, 5'h00, win_on_r, 25'h0000000};
      `OFS_WIN_BASE: rd_mux = `WIN_BASE_VAL;
      `OFS_WIN_POS_STEP: rd_mux = `WIN_STEP_VAL;
      `OFS_WIN_SIZE_STEP: rd_mux = `WIN_STEP_VAL;
      `OFS_WIN_ORIGIN: rd_mux = origin_r;
      `OFS_WIN_EXTENT: rd_mux = extent_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame store and replay

  camera_regs_pkg::replay_state_t state_r;
  camera_regs_pkg::send_src_t src_r;
  logic [11:0] wr_ptr_r, rd_ptr_r, remain_r, count_eff, slot_r;
  logic retx_valid_r, send_r, undef_r, store_wr_r;
  logic [11:0] store_slot_r;
  logic store_sel, start_multi, start_single, pop_now, arrive_wr, full;

  function automatic logic [11:0] wrap(input logic [11:0] p, input logic [11:0] c);
    wrap = (p + 12'h001 >= c) ? 12'h000 : p + 12'h001;
  endfunction

  assign store_sel = sel_r && !continuous_on;
  assign start_multi = state_r == camera_regs_pkg::st_idle && store_sel && multi_shot_req;
  assign start_single = state_r == camera_regs_pkg::st_idle && store_sel && !multi_shot_req &&
    single_shot_req && tx_ready;
  assign count_eff = (replay_count == 12'h000) ? 12'h001 : replay_count;
  assign full = fill_r == cap_r;
  assign pop_now = state_r == camera_regs_pkg::st_send && !continuous_on && tx_ready &&
    fill_r != 12'h000 && !reinit;
  assign arrive_wr = frame_arrive && store_on_r && !reinit;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= camera_regs_pkg::st_idle;
      remain_r <= 12'h000;
    end else if (ce) begin
      unique case (state_r)
        camera_regs_pkg::st_idle: begin
          if (start_multi) begin
            state_r <= camera_regs_pkg::st_send;
            remain_r <= count_eff;
          end
        end
        camera_regs_pkg::st_send: begin
          // continuous acquisition aborts a replay in progress
          if (continuous_on || (tx_ready && remain_r == 12'h001)) begin
            state_r <= camera_regs_pkg::st_idle;
            remain_r <= 12'h000;
          end else if (tx_ready) begin
            remain_r <= remain_r - 12'h001;
          end
        end
      endcase
    end
  end

  // empty store: the rest of a multi shot comes from the retransmit buffer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      send_r <= 1'b0;
      src_r <= camera_regs_pkg::src_live;
      slot_r <= 12'h000;
      undef_r <= 1'b0;
    end else if (ce) begin
      send_r <= start_single || (state_r == camera_regs_pkg::st_send && tx_ready &&
        !continuous_on);
      src_r <= pop_now ? camera_regs_pkg::src_store : camera_regs_pkg::src_retx;
      slot_r <= rd_ptr_r;
      undef_r <= !pop_now && !retx_valid_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) retx_valid_r <= 1'b0;
    else if (ce) begin
      if (send_r || live_sent) retx_valid_r <= 1'b1;
      else if (reinit) retx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cap_r <= 12'h001;
      fill_r <= 12'h000;
      wr_ptr_r <= 12'h000;
      rd_ptr_r <= 12'h000;
      store_wr_r <= 1'b0;
      store_slot_r <= 12'h000;
    end else if (ce) begin
      store_wr_r <= arrive_wr;
      store_slot_r <= wr_ptr_r;
      if (reinit) begin
        cap_r <= (store_capacity_in == 12'h000) ? 12'h001 : store_capacity_in;
        fill_r <= 12'h000;
        wr_ptr_r <= 12'h000;
        rd_ptr_r <= 12'h000;
      end else begin
        if (arrive_wr) wr_ptr_r <= wrap(wr_ptr_r, cap_r);
        if (pop_now || (arrive_wr && full)) rd_ptr_r <= wrap(rd_ptr_r, cap_r);
        if (arrive_wr && !pop_now && !full) fill_r <= fill_r + 12'h001;
        else if (pop_now && !arrive_wr) fill_r <= fill_r - 12'h001;
      end
    end
  end

  assign frame_send = send_r;
  assign frame_send_src = src_r;
  assign frame_send_slot = slot_r;
  assign frame_send_undef = undef_r;
  assign store_write = store_wr_r;
  assign store_slot = store_slot_r;
  assign flash_commit = commit_r;
  assign flash_rd_word = flash_rd_r;
  assign strobe_ref_trigger = strobe_ref_r;
  assign strobe_span = span_r;
  assign aux_supply_on = aux_on_r;
  assign window_on = win_on_r;
  assign window_origin = origin_r;
  assign window_extent = extent_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || !ce);

  sequence s_window_fill;
    dirty_r && other_access && !wr_data;
  endsequence
  sequence s_multi_go;
    start_multi && !continuous_on;
  endsequence

  property p_cont_blocks;
    continuous_on |=> !frame_send;
  endproperty
  a_cont_blocks: assert property (p_cont_blocks) else $error("send during continuous");
  property p_multi_count;
    s_multi_go |=> state_r == camera_regs_pkg::st_send && remain_r == $past(count_eff);
  endproperty
  a_multi_count: assert property (p_multi_count) else $error("multi count wrong");
  property p_single_retx;
    start_single |=> frame_send && frame_send_src == camera_regs_pkg::src_retx;
  endproperty
  a_single_retx: assert property (p_single_retx) else $error("single shot not retx");
  property p_overwrite;
    arrive_wr && full && !pop_now |=> fill_r == $past(fill_r) && store_write;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("full store grew");
  property p_reinit;
    reinit |=> fill_r == 12'h000 && cap_r != 12'h000;
  endproperty
  a_reinit: assert property (p_reinit) else $error("store not reinitialised");
  property p_commit;
    s_window_fill |=> flash_commit && !dirty_r;
  endproperty
  a_commit: assert property (p_commit) else $error("dirty page not committed");
  property p_aux_default;
    !$past(resetn) |-> !aux_supply_on;
  endproperty
  a_aux_default: assert property (p_aux_default) else $error("aux not off after reset");
  property p_win_lock;
    wr_org && !win_on_r |=> $stable(window_origin);
  endproperty
  a_win_lock: assert property (p_win_lock) else $error("origin written while off");
  property p_span_valid;
    wr_strobe && wd_strobe[`STB_SPAN_MSB:`STB_SPAN_LSB] == 2'h3 |=> $stable(strobe_span);
  endproperty
  a_span_valid: assert property (p_span_valid) else $error("invalid span stored");

endmodule // camera_control_status_regs

// ==== shared/camera_regs_defs.svh ====
// Behaviour
// - stored frames go out only without continuous acquisition
// - select=1: multi shot replays store, single shot resends
// - multi shot sends replay-count stored frames
// - single shot resends last retransmit-buffer frame
// - store on: each acquired frame enters ring
// - full ring overwrites its oldest frame
// - every sent frame copied; no prior frame: undefined
// - store-on write or format change reinitialises store
// - bit0 store on, bit1 source, ignored when continuous
// - capacity nonzero in 8-19, fill in 20-31
// - unwritten flash bits read as one
// - window writes commit on control write or access
// - clean bit: 0 dirty, write 1 programs
// - presence bit reads one for implemented features
// - flash window holds a full 32-bit word
// - strobe reference bit: 0 integration, 1 trigger
// - read-only shutter kind bit 13
// - span field 14-15, invalid codes refused
// - aux supply bit 31, default off
// - window on bit 6; off locks other fields
`ifndef CAMERA_REGS_DEFS_SVH
`define CAMERA_REGS_DEFS_SVH
`define OFS_REPLAY 16'h0634
`define OFS_STROBE 16'h1104
`define OFS_FLASH_CTRL 16'h1240
`define OFS_FLASH_DATA 16'h1244
`define OFS_AUX 16'h19D0
`define OFS_WIN_CTRL 16'h1A70
`define OFS_WIN_BASE 16'h1A74
`define OFS_WIN_POS_STEP 16'h1A80
`define OFS_WIN_SIZE_STEP 16'h1A84
`define OFS_WIN_ORIGIN 16'h1A88
`define OFS_WIN_EXTENT 16'h1A8C
`define WIN_BASE_VAL 32'h3C0006A0
`define WIN_STEP_VAL 32'h00010001
// msb-first numbering: documented bit n is physical bit 31-n
`define PRESENT_BIT 31
`define RPL_ON_BIT 31
`define RPL_SEL_BIT 30
`define HI_FIELD_MSB 23
`define HI_FIELD_LSB 12
`define LO_FIELD_MSB 11
`define LO_FIELD_LSB 0
`define FLASH_CLEAN_BIT 25
`define FLASH_PAGE_EXP 12'h008
`define FLASH_COUNT_EXP 12'h00B
`define PAGE_WORDS 64
`define STB_REF_BIT 31
`define STB_SHUT_BIT 18
`define STB_SPAN_MSB 17
`define STB_SPAN_LSB 16
`define AUX_ON_BIT 0
`define WIN_ON_BIT 25
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== shared/camera_regs_pkg.sv ====
package camera_regs_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_send = 2'b10
  } replay_state_t;
  typedef enum logic [1:0] {
    src_live = 2'h0,
    src_store = 2'h1,
    src_retx = 2'h2
  } send_src_t;
endpackage

// ==== verification/camera_control_status_regs_bench.sv ====
`timescale 1ns/1ps
`include "camera_regs_defs.svh"
module camera_control_status_regs_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, strobe_span;
  logic [31:0] s_axi_rdata, flash_rd_word, window_origin, window_extent;
  logic continuous_on = 1'b0, single_shot_req = 1'b0, multi_shot_req = 1'b0;
  logic frame_arrive = 1'b0, tx_ready = 1'b1, global_reset_shutter = 1'b0;
  logic ce = 1'b1, last_undef = 1'b0;
  logic [11:0] last_slot = 12'h000, last_wslot = 12'h000;
  logic [11:0] replay_count = 12'h001, store_capacity_in = 12'h004;
  logic frame_send, frame_send_undef, store_write, flash_commit;
  logic strobe_ref_trigger, aux_supply_on, window_on;
  logic [11:0] frame_send_slot, store_slot;
  camera_regs_pkg::send_src_t frame_send_src;
  camera_regs_pkg::send_src_t last_src = camera_regs_pkg::src_live;
  int n_errors = 0, cmp_count = 0, cyc = 0, n_send = 0, n_wr = 0, n_commit = 0;

  always #4 core_clk = ~core_clk;

  camera_control_status_regs dut (
    .core_clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .continuous_on,
    .single_shot_req, .multi_shot_req, .replay_count, .frame_arrive, .live_sent(1'b0),
    .fmt_change(1'b0), .store_capacity_in, .tx_ready, .global_reset_shutter,
    .flash_rd_idx(6'h00), .frame_send, .frame_send_src, .frame_send_slot,
    .frame_send_undef, .store_write, .store_slot, .flash_commit, .flash_rd_word,
    .strobe_ref_trigger, .strobe_span, .aux_supply_on, .window_on, .window_origin,
    .window_extent
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters, so checks need not catch one-cycle strobes in the act
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (resetn && frame_send) begin
      n_send <= n_send + 1;
      last_src <= frame_send_src;
      last_slot <= frame_send_slot;
      last_undef <= frame_send_undef;
    end
    if (resetn && store_write) begin
      n_wr <= n_wr + 1;
      last_wslot <= store_slot;
    end
    if (resetn && flash_commit) n_commit <= n_commit + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus master: ready sampled mid-cycle, inputs only change after a rising edge
  task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
        return;
      end
    end
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
  endtask

  task automatic axr(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
        chk(d, e);
        return;
      end
    end
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idents;
    axr(`OFS_FLASH_CTRL, 32'h8200800B, `RESP_OKAY);
    axr(`OFS_REPLAY, 32'h00001000, `RESP_OKAY);
    axr(`OFS_AUX, 32'h80000000, `RESP_OKAY);
    axr(`OFS_WIN_BASE, `WIN_BASE_VAL, `RESP_OKAY);
    chk((`WIN_BASE_VAL << 2) & 32'h0FFFFFFF, {16'h0000, `OFS_WIN_POS_STEP});
    axr(`OFS_WIN_SIZE_STEP, `WIN_STEP_VAL, `RESP_OKAY);
    axr(16'h0010, 32'h00000000, `RESP_SLVERR);
    axw(16'h0010, 32'hFFFFFFFF, `RESP_SLVERR);
    chk(flash_rd_word, 32'hFFFFFFFF);
    $display("test idents done");
  endtask

  task automatic t_flash;
    int c0;
    c0 = n_commit;
    axw(`OFS_FLASH_DATA, 32'h12345678, `RESP_OKAY);
    axr(`OFS_FLASH_CTRL, 32'h8000800B, `RESP_OKAY);
    chk(flash_rd_word, 32'h12345678);
    axw(`OFS_FLASH_CTRL, 32'h00000000, `RESP_OKAY);
    chk(32'(n_commit - c0), 32'h0);
    axw(`OFS_FLASH_CTRL, 32'h02000000, `RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(n_commit - c0), 32'h1);
    chk(flash_rd_word, 32'hFFFFFFFF);
    axr(`OFS_FLASH_CTRL, 32'h8200800B, `RESP_OKAY);
    axw(`OFS_FLASH_DATA, 32'h0000ABCD, `RESP_OKAY);
    axr(`OFS_AUX, 32'h80000000, `RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(n_commit - c0), 32'h2);
    $display("test flash done");
  endtask

  task automatic t_strobe_aux;
    axw(`OFS_STROBE, 32'h00030000, `RESP_OKAY);
    axw(`OFS_STROBE, 32'h00010000, `RESP_OKAY);
    axr(`OFS_STROBE, 32'h00000000, `RESP_OKAY);
    global_reset_shutter <= 1'b1;
    axw(`OFS_STROBE, 32'h8001FFFF, `RESP_OKAY);
    axr(`OFS_STROBE, 32'h80050000, `RESP_OKAY);
    chk({31'h0, strobe_ref_trigger}, 32'h1);
    chk({30'h0, strobe_span}, 32'h1);
    ce <= 1'b0;
    fork
      axw(`OFS_AUX, 32'hFFFFFFFF, `RESP_OKAY);
      begin
        repeat (4) @(posedge core_clk);
        chk({31'h0, aux_supply_on}, 32'h0);
        ce <= 1'b1;
      end
    join
    axr(`OFS_AUX, 32'h80000001, `RESP_OKAY);
    chk({31'h0, aux_supply_on}, 32'h1);
    $display("test strobe and aux done");
  endtask

  task automatic t_window;
    axw(`OFS_WIN_ORIGIN, 32'h00050006, `RESP_OKAY);
    axr(`OFS_WIN_ORIGIN, 32'h00000000, `RESP_OKAY);
    axw(`OFS_WIN_CTRL, 32'h02000000, `RESP_OKAY);
    axr(`OFS_WIN_CTRL, 32'h82000000, `RESP_OKAY);
    axw(`OFS_WIN_EXTENT, 32'h00200010, `RESP_OKAY);
    chk({31'h0, window_on}, 32'h1);
    chk(window_extent, 32'h00200010);
    axw(`OFS_WIN_ORIGIN, 32'h00050006, `RESP_OKAY);
    chk(window_origin, 32'h00050006);
    axr(`OFS_WIN_EXTENT, 32'h00200010, `RESP_OKAY);
    $display("test window done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle request pulse, then time for the replay engine to drain
  task automatic shot(input logic m, input int exp_n, input logic [1:0] exp_src);
    int s0;
    s0 = n_send;
    @(posedge core_clk);
    if (m) multi_shot_req <= 1'b1;
    else single_shot_req <= 1'b1;
    @(posedge core_clk);
    multi_shot_req <= 1'b0;
    single_shot_req <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(32'(n_send - s0), 32'(exp_n));
    if (exp_n > 0) chk({30'h0, last_src}, {30'h0, exp_src});
  endtask

  task automatic t_replay;
    axw(`OFS_REPLAY, 32'hFFFFFFFF, `RESP_OKAY);
    axr(`OFS_REPLAY, 32'hC0004000, `RESP_OKAY);
    repeat (5) begin
      @(posedge core_clk);
      frame_arrive <= 1'b1;
      @(posedge core_clk);
      frame_arrive <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    chk(32'(n_wr), 32'h5);
    chk({20'h0, last_wslot}, 32'h0);
    axr(`OFS_REPLAY, 32'hC0004004, `RESP_OKAY);
    replay_count <= 12'h002;
    shot(1'b1, 2, camera_regs_pkg::src_store);
    chk({20'h0, last_slot}, 32'h2);
    axr(`OFS_REPLAY, 32'hC0004002, `RESP_OKAY);
    shot(1'b0, 1, camera_regs_pkg::src_retx);
    chk({31'h0, last_undef}, 32'h0);
    axw(`OFS_REPLAY, 32'hFFFFFFFF, `RESP_OKAY);
    shot(1'b0, 1, camera_regs_pkg::src_retx);
    chk({31'h0, last_undef}, 32'h1);
    continuous_on <= 1'b1;
    shot(1'b0, 0, camera_regs_pkg::src_retx);
    $display("test replay done");
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    t_idents();
    t_flash();
    t_strobe_aux();
    t_window();
    t_replay();
    report_and_stop();
  end
endmodule // camera_control_status_regs_bench
